// ### adc_core_model.sv
// Behavioural model of the converter core that answers conversion requests
`timescale 1ns/1ps
module adc_core_model #(
  parameter int DELAY = 3
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic convert_request,
  input wire logic [13:0] res_in,
  input wire logic [7:0] cal_in,
  output logic adc_clk_tick,
  output logic result_valid,
  output logic [13:0] result_data,
  output logic [7:0] cal_offset
);
  int cnt;
  // ----------------------------------------
  // Converter clock tick and delayed answer
  // ----------------------------------------
  always_ff @(posedge core_clk)
  begin
    adc_clk_tick <= rst_b & ~adc_clk_tick;
    result_valid <= rst_b && cnt == 1;
    if (!rst_b || cnt == 0)
      cnt <= (rst_b && convert_request) ? DELAY : 0;
    else
      cnt <= cnt - 1;
  end
  // ----------------------------------------
  // Data lines show no stale value outside the answer
  // ----------------------------------------
  assign result_data = result_valid ? res_in : ~res_in;
  assign cal_offset = result_valid ? cal_in : ~cal_in;
endmodule : adc_core_model

// ### adc_ctrl.sv
// Converter offset, result byte pair and sample timing control with Avalon-MM slave
`timescale 1ns/1ps
`include "adc_params.svh"
module adc_ctrl #(
  parameter int ADDR_W = 12,
  parameter int RES_W = 14
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic start_strobe,
  input wire logic [1:0] start_code,
  input wire logic event_trigger,
  input wire logic adc_clk_tick,
  input wire logic result_valid,
  input wire logic [RES_W-1:0] result_data,
  input wire logic [7:0] cal_offset,
  output logic sample_active,
  output logic settle_active,
  output logic convert_request,
  output logic calibrate_mode
);
  initial
  begin
    if (RES_W != 14)
      $error("RES_W must be 14");
    if (ADDR_W < 12)
      $error("ADDR_W too small for register map");
  end

  timing_if tif ();

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] offset_calibration;
  logic [7:0] result_low_byte;
  logic [7:0] sample_timing;
  logic [7:0] control_config;
  logic [RES_W-1:0] hold_result;
  adc_pkg::conv_state_t conv_state;
  adc_pkg::conv_state_t next_conv_state;

  wire resolution_select = control_config[`ADC_CFG_RES_BIT];
  wire data_format_select = control_config[`ADC_CFG_FMT_BIT];
  wire [1:0] input_mode_select = control_config[`ADC_CFG_MODE_HI:`ADC_CFG_MODE_LO];

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire bus_req = avs_read || avs_write;
  wire accept = bus_req && !avs_waitrequest;
  wire wr_lane = avs_write && accept && avs_byteenable[0];
  wire [11:0] word_idx = avs_address[11:0];
  wire sel_offset = (word_idx == `ADC_OFFSET_IDX);
  wire sel_high = (word_idx == `ADC_RES_HIGH_IDX);
  wire sel_low = (word_idx == `ADC_RES_LOW_IDX);
  wire sel_timing = (word_idx == `ADC_TIMING_IDX);
  wire sel_config = (word_idx == `ADC_CONFIG_IDX);
  wire high_read = avs_read && accept && sel_high;
  wire [7:0] result_high_byte = {`ADC_ZERO2, hold_result[13:8]};
  wire [7:0] low_latch = resolution_select ? hold_result[7:0]
    : {hold_result[7:2], `ADC_ZERO2};
  wire [7:0] read_byte = sel_offset ? offset_calibration
    : sel_high ? result_high_byte
    : sel_low ? result_low_byte
    : sel_timing ? sample_timing
    : sel_config ? control_config
    : 8'h00;

  // ----------------------------------------
  // Offset correction
  // ----------------------------------------
  wire [1:0] off_low = resolution_select ? offset_calibration[1:0] : `ADC_ZERO2;
  wire [7:0] off_used = {offset_calibration[7:2], off_low};
  wire [14:0] off_ext = {{7{off_used[7]}}, off_used};
  wire [14:0] raw_ext = {result_data[13], result_data};
  wire [14:0] diff = raw_ext - off_ext;
  wire diff_ovf = diff[14] != diff[13];
  wire [13:0] diff_sat = diff_ovf ? (diff[14] ? `ADC_SAT_NEG : `ADC_SAT_POS) : diff[13:0];
  wire [13:0] corrected = data_format_select ? diff_sat : result_data;
  wire [13:0] aligned = resolution_select ? corrected : {corrected[13:2], `ADC_ZERO2};

  // ----------------------------------------
  // Conversion sequencing
  // ----------------------------------------
  wire sw_start = start_strobe && (start_code == `ADC_START_NORMAL);
  wire cal_start = start_strobe && (start_code == `ADC_START_CAL);
  wire any_start = (sw_start || cal_start || event_trigger)
    && (conv_state == adc_pkg::CV_IDLE);
  wire conv_end = (conv_state == adc_pkg::CV_CONVERT) && result_valid;
  wire normal_end = conv_end && !calibrate_mode;
  wire cal_end = conv_end && calibrate_mode;

  assign tif.start = any_start;
  assign tif.tick = adc_clk_tick;
  assign tif.sampling_time_field = sample_timing[`ADC_ST_HI:`ADC_ST_LO];
  assign tif.settling_time_field = sample_timing[`ADC_SST_HI:`ADC_SST_LO];
  assign tif.input_mode_select = input_mode_select;
  assign sample_active = tif.sample_active;
  assign settle_active = tif.settle_active;

  adc_sample_timer #(
    .CNT_W(11)
  ) u_timer (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .tif(tif)
  );

  always_comb
  begin
    next_conv_state = conv_state;
    unique case (conv_state)
      adc_pkg::CV_IDLE:
      begin
        if (any_start)
          next_conv_state = adc_pkg::CV_TIMING;
      end
      adc_pkg::CV_TIMING:
      begin
        if (tif.done)
          next_conv_state = adc_pkg::CV_CONVERT;
      end
      adc_pkg::CV_CONVERT:
      begin
        if (result_valid)
          next_conv_state = adc_pkg::CV_IDLE;
      end
      default:
        next_conv_state = adc_pkg::CV_IDLE;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      conv_state <= adc_pkg::CV_IDLE;
      calibrate_mode <= 1'b0;
      convert_request <= 1'b0;
    end
    else
    begin
      conv_state <= next_conv_state;
      convert_request <= (conv_state == adc_pkg::CV_TIMING) && tif.done;
      if (any_start)
        calibrate_mode <= cal_start;
    end
  end

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end
    else
    begin
      avs_waitrequest <= !(bus_req && avs_waitrequest);
      avs_readdata <= {`ADC_READ_PAD, read_byte};
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      offset_calibration <= `ADC_OFFSET_RST;
    else if (cal_end)
      offset_calibration <= cal_offset;
    else if (wr_lane && sel_offset)
      offset_calibration <= avs_writedata[7:0];
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      sample_timing <= `ADC_TIMING_RST;
      control_config <= `ADC_CONFIG_RST;
    end
    else
    begin
      if (wr_lane && sel_timing)
        sample_timing <= avs_writedata[7:0];
      if (wr_lane && sel_config)
        control_config <= avs_writedata[7:0];
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      hold_result <= `ADC_HOLD_RST;
      result_low_byte <= `ADC_RES_LOW_RST;
    end
    else
    begin
      if (normal_end)
        hold_result <= aligned;
      if (high_read)
        result_low_byte <= low_latch;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_bus_answer: assert property (@(posedge core_clk) disable iff (!rst_b)
    bus_req && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  a_low_latch: assert property (@(posedge core_clk) disable iff (!rst_b)
    high_read |=> result_low_byte == $past(low_latch))
    else $error("low byte not latched on high read");
  a_low_stable: assert property (@(posedge core_clk) disable iff (!rst_b)
    !high_read |=> $stable(result_low_byte))
    else $error("low byte changed without high read");
  a_high_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
    !normal_end |=> $stable(result_high_byte))
    else $error("high byte changed without result");
  a_cal_offset: assert property (@(posedge core_clk) disable iff (!rst_b)
    cal_end |=> offset_calibration == $past(cal_offset))
    else $error("calibration not stored");
  a_unsigned_raw: assert property (@(posedge core_clk) disable iff (!rst_b)
    normal_end && !data_format_select && resolution_select |=> hold_result == $past(result_data))
    else $error("unsigned result altered");
  a_signed_corr: assert property (@(posedge core_clk) disable iff (!rst_b)
    normal_end && data_format_select && resolution_select && !diff_ovf
    |=> hold_result == $past(result_data - {{6{off_used[7]}}, off_used}))
    else $error("signed offset not applied");
  a_start_timing: assert property (@(posedge core_clk) disable iff (!rst_b)
    any_start |=> sample_active ##0 (conv_state == adc_pkg::CV_TIMING))
    else $error("timing not started");
  a_sw_write: assert property (@(posedge core_clk) disable iff (!rst_b)
    wr_lane && sel_offset && !cal_end |=> offset_calibration == $past(avs_writedata[7:0]))
    else $error("offset write lost");
  c_cal_run: cover property (@(posedge core_clk) disable iff (!rst_b) cal_end);
  c_high_read: cover property (@(posedge core_clk) disable iff (!rst_b)
    high_read && !resolution_select);
  c_event_conv: cover property (@(posedge core_clk) disable iff (!rst_b)
    event_trigger && any_start);
  c_signed_end: cover property (@(posedge core_clk) disable iff (!rst_b)
    normal_end && data_format_select);
endmodule : adc_ctrl

// ### adc_params.svh
// Register map, field positions, codes and timing counts of the converter control block
`ifndef ADC_PARAMS_SVH
`define ADC_PARAMS_SVH
// Register word indices
`define ADC_OFFSET_IDX 12'hf75
`define ADC_RES_HIGH_IDX 12'hf76
`define ADC_RES_LOW_IDX 12'hf77
`define ADC_TIMING_IDX 12'hf78
`define ADC_CONFIG_IDX 12'hf70
// Reset values
`define ADC_OFFSET_RST 8'h00
`define ADC_RES_HIGH_RST 8'h00
`define ADC_RES_LOW_RST 8'h00
`define ADC_TIMING_RST 8'h00
`define ADC_CONFIG_RST 8'h00
`define ADC_HOLD_RST 14'h0000
`define ADC_READ_PAD 24'h00_0000
`define ADC_ZERO2 2'h0
// Config register fields
`define ADC_CFG_RES_BIT 0
`define ADC_CFG_FMT_BIT 1
`define ADC_CFG_MODE_HI 3
`define ADC_CFG_MODE_LO 2
// Sample timing fields
`define ADC_ST_HI 7
`define ADC_ST_LO 4
`define ADC_SST_HI 3
`define ADC_SST_LO 0
// Start command codes
`define ADC_START_NORMAL 2'h1
`define ADC_START_CAL 2'h2
// Signed result saturation limits
`define ADC_SAT_NEG 14'h2000
`define ADC_SAT_POS 14'h1fff
// Sampling time in converter clocks per code
`define ADC_ST_C0 11'h002
`define ADC_ST_C1 11'h002
`define ADC_ST_C2 11'h004
`define ADC_ST_C3 11'h008
`define ADC_ST_C4 11'h010
`define ADC_ST_C5 11'h020
`define ADC_ST_C6 11'h040
`define ADC_ST_C7 11'h060
`define ADC_ST_C8 11'h080
`define ADC_ST_C9 11'h0c0
`define ADC_ST_CA 11'h100
`define ADC_ST_CB 11'h140
`define ADC_ST_CC 11'h180
`define ADC_ST_CD 11'h200
`define ADC_ST_CE 11'h300
`define ADC_ST_CF 11'h400
`define ADC_CNT_ONE 11'h001
`define ADC_CNT_ZERO 11'h000
`endif

// ### adc_pkg.sv
// Types shared by the converter control modules
package adc_pkg;
  typedef enum logic [2:0] {
    TM_IDLE = 3'b001,
    TM_SAMPLE = 3'b010,
    TM_SETTLE = 3'b100
  } timer_state_t;
  typedef enum logic [2:0] {
    CV_IDLE = 3'b001,
    CV_TIMING = 3'b010,
    CV_CONVERT = 3'b100
  } conv_state_t;
endpackage : adc_pkg

// ### adc_sample_timer.sv
// Sampling and settling phase timer counted in converter clocks
`timescale 1ns/1ps
`include "adc_params.svh"
module adc_sample_timer #(
  parameter int CNT_W = 11
) (
  input wire logic core_clk,
  input wire logic rst_b,
  timing_if.timer tif
);
  initial
  begin
    if (CNT_W < 11)
      $error("CNT_W too small for 1024 clocks");
  end

  // ----------------------------------------
  // Count selection
  // ----------------------------------------
  function automatic logic [10:0] sample_clocks(input logic [3:0] code);
    logic [10:0] c;
    c = `ADC_ST_C0;
    unique case (code)
      4'h0: c = `ADC_ST_C0;
      4'h1: c = `ADC_ST_C1;
      4'h2: c = `ADC_ST_C2;
      4'h3: c = `ADC_ST_C3;
      4'h4: c = `ADC_ST_C4;
      4'h5: c = `ADC_ST_C5;
      4'h6: c = `ADC_ST_C6;
      4'h7: c = `ADC_ST_C7;
      4'h8: c = `ADC_ST_C8;
      4'h9: c = `ADC_ST_C9;
      4'ha: c = `ADC_ST_CA;
      4'hb: c = `ADC_ST_CB;
      4'hc: c = `ADC_ST_CC;
      4'hd: c = `ADC_ST_CD;
      4'he: c = `ADC_ST_CE;
      4'hf: c = `ADC_ST_CF;
    endcase
    return c;
  endfunction : sample_clocks

  adc_pkg::timer_state_t state;
  adc_pkg::timer_state_t next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  wire [CNT_W-1:0] samp_load = CNT_W'(sample_clocks(tif.sampling_time_field) - `ADC_CNT_ONE);
  wire long_settle = tif.input_mode_select[1];
  wire [CNT_W-1:0] settle_load = long_settle ? CNT_W'(tif.settling_time_field) : '0;
  wire cnt_end = tif.tick && (cnt == '0);

  // ----------------------------------------
  // Phase sequencer
  // ----------------------------------------
  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    unique case (state)
      adc_pkg::TM_IDLE:
      begin
        if (tif.start)
        begin
          next_state = adc_pkg::TM_SAMPLE;
          next_cnt = samp_load;
        end
      end
      adc_pkg::TM_SAMPLE:
      begin
        if (cnt_end)
        begin
          next_state = adc_pkg::TM_SETTLE;
          next_cnt = settle_load;
        end
        else if (tif.tick)
          next_cnt = cnt - 1'b1;
      end
      adc_pkg::TM_SETTLE:
      begin
        if (cnt_end)
          next_state = adc_pkg::TM_IDLE;
        else if (tif.tick)
          next_cnt = cnt - 1'b1;
      end
      default:
      begin
        next_state = adc_pkg::TM_IDLE;
        next_cnt = '0;
      end
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      state <= adc_pkg::TM_IDLE;
      cnt <= '0;
      tif.sample_active <= 1'b0;
      tif.settle_active <= 1'b0;
      tif.done <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      tif.sample_active <= (next_state == adc_pkg::TM_SAMPLE);
      tif.settle_active <= (next_state == adc_pkg::TM_SETTLE);
      tif.done <= (state == adc_pkg::TM_SETTLE) && cnt_end;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_sample_load: assert property (@(posedge core_clk) disable iff (!rst_b)
    (state == adc_pkg::TM_IDLE) && tif.start |=> tif.sample_active && (cnt == $past(samp_load)))
    else $error("sampling count not loaded");
  a_settle_short: assert property (@(posedge core_clk) disable iff (!rst_b)
    tif.settle_active && !tif.input_mode_select[1] && tif.tick |=> !tif.settle_active && tif.done)
    else $error("short settle exceeded one clock");
  a_settle_load: assert property (@(posedge core_clk) disable iff (!rst_b)
    tif.sample_active && cnt_end && long_settle |=> cnt == CNT_W'($past(tif.settling_time_field)))
    else $error("settling count wrong");
  c_long_settle: cover property (@(posedge core_clk) disable iff (!rst_b)
    tif.settle_active && long_settle && (tif.settling_time_field == 4'hf));
endmodule : adc_sample_timer

// ### tb.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module tb;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [11:0] avs_address = 12'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic start_strobe = 1'b0;
  logic [1:0] start_code = 2'h0;
  logic event_trigger = 1'b0;
  logic adc_clk_tick, result_valid, sample_active, settle_active, convert_request, calibrate_mode;
  logic [13:0] result_data;
  logic [13:0] res_in = 14'h0000;
  logic [7:0] cal_offset;
  logic [7:0] cal_in = 8'h00;
  logic [7:0] rd_data;
  logic [15:0] st_tab [16] = '{16'h0002, 16'h0002, 16'h0004, 16'h0008, 16'h0010, 16'h0020,
    16'h0040, 16'h0060, 16'h0080, 16'h00c0, 16'h0100, 16'h0140, 16'h0180, 16'h0200,
    16'h0300, 16'h0400};
  int n_mismatch = 0;
  int comparisons = 0;
  int n_samp = 0;
  int n_sett = 0;
  logic wait_smp = 1'b1;
  logic rv_smp = 1'b0;
  logic [31:0] rdata_smp = 32'h0000_0000;
  always #2.5 core_clk = ~core_clk;
  adc_ctrl DUT (.core_clk(core_clk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .start_strobe(start_strobe), .start_code(start_code),
    .event_trigger(event_trigger), .adc_clk_tick(adc_clk_tick), .result_valid(result_valid),
    .result_data(result_data), .cal_offset(cal_offset), .sample_active(sample_active),
    .settle_active(settle_active), .convert_request(convert_request),
    .calibrate_mode(calibrate_mode));
  adc_core_model core (.core_clk(core_clk), .rst_b(rst_b), .convert_request(convert_request),
    .res_in(res_in), .cal_in(cal_in), .adc_clk_tick(adc_clk_tick),
    .result_valid(result_valid), .result_data(result_data), .cal_offset(cal_offset));
  // ----------------------------------------
  // Converter clocks seen in each phase
  // ----------------------------------------
  always @(negedge core_clk)
  begin
    wait_smp = avs_waitrequest;
    rv_smp = result_valid;
    rdata_smp = avs_readdata;
    if (sample_active === 1'b1 && adc_clk_tick === 1'b1)
      n_samp = n_samp + 1;
    if (settle_active === 1'b1 && adc_clk_tick === 1'b1)
      n_sett = n_sett + 1;
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task summarize;
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : summarize
  task chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task note(input string name);
    $display("Test %s ended, mismatches so far %0d", name, n_mismatch);
  endtask : note
  task bus(input logic wr, input logic [11:0] a, input logic [7:0] d, input logic be);
    int k;
    @(posedge core_clk);
    avs_address <= a;
    avs_read <= ~wr;
    avs_write <= wr;
    avs_writedata <= {24'h00_0000, d};
    avs_byteenable <= {3'h0, be};
    k = 0;
    do
    begin
      @(posedge core_clk);
      k++;
    end
    while (wait_smp !== 1'b0 && k < 50);
    rd_data = rdata_smp[7:0];
    if (k >= 50)
      n_mismatch++;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task wr(input logic [11:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 1'b1);
  endtask : wr
  task rd_chk(input logic [11:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00, 1'b1);
    chk({8'h00, rd_data}, {8'h00, exp});
  endtask : rd_chk
  task conv(input logic [1:0] code, input logic ev);
    int k;
    @(posedge core_clk);
    start_strobe <= ~ev;
    start_code <= code;
    event_trigger <= ev;
    n_samp = 0;
    n_sett = 0;
    @(posedge core_clk);
    start_strobe <= 1'b0;
    event_trigger <= 1'b0;
    k = 0;
    while (rv_smp !== 1'b1 && k < 5000)
    begin
      @(posedge core_clk);
      k++;
    end
    if (k >= 5000)
      n_mismatch++;
    repeat (2) @(posedge core_clk);
  endtask : conv
  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  initial
  begin
    #200000;
    n_mismatch++;
    summarize();
  end
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial
  begin
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 4; i++)
      rd_chk(12'hf75 + 12'(i), 8'h00);
    wr(12'hf7f, 8'h77);
    rd_chk(12'hf7f, 8'h00);
    note("reset");
    wr(12'hf75, 8'h5a);
    rd_chk(12'hf75, 8'h5a);
    bus(1'b1, 12'hf75, 8'h33, 1'b0);
    rd_chk(12'hf75, 8'h5a);
    wr(12'hf76, 8'hff);
    rd_chk(12'hf76, 8'h00);
    wr(12'hf78, 8'hc3);
    rd_chk(12'hf78, 8'hc3);
    note("access");
    wr(12'hf78, 8'h00);
    wr(12'hf70, 8'h01);
    res_in = 14'h2345;
    conv(2'h1, 1'b0);
    chk({15'h0000, calibrate_mode}, 16'h0000);
    rd_chk(12'hf77, 8'h00);
    rd_chk(12'hf76, 8'h23);
    rd_chk(12'hf77, 8'h45);
    wr(12'hf75, 8'h00);
    rd_chk(12'hf75, 8'h00);
    note("unsigned");
    wr(12'hf70, 8'h03);
    wr(12'hf75, 8'hfb);
    res_in = 14'h0100;
    conv(2'h1, 1'b1);
    rd_chk(12'hf76, 8'h01);
    rd_chk(12'hf77, 8'h05);
    wr(12'hf70, 8'h02);
    wr(12'hf75, 8'h17);
    res_in = 14'h0403;
    conv(2'h1, 1'b0);
    rd_chk(12'hf76, 8'h03);
    rd_chk(12'hf77, 8'hec);
    note("signed");
    cal_in = 8'ha6;
    conv(2'h2, 1'b0);
    chk({15'h0000, calibrate_mode}, 16'h0001);
    rd_chk(12'hf75, 8'ha6);
    rd_chk(12'hf76, 8'h03);
    @(posedge core_clk);
    start_strobe <= 1'b1;
    start_code <= 2'h3;
    @(posedge core_clk);
    start_strobe <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk({15'h0000, sample_active}, 16'h0000);
    note("calibration");
    for (int c = 0; c < 16; c++)
    begin
      wr(12'hf70, {4'h0, 2'(c), 2'h0});
      wr(12'hf78, {4'(c), 4'(c)});
      conv(2'h1, c[0]);
      chk(16'(n_samp), st_tab[c]);
      chk(16'(n_sett), c[1] ? 16'(c + 1) : 16'h0001);
    end
    note("timing");
    summarize();
  end
endmodule : tb

// ### timing_if.sv
// Carrier between the control core and the sample timer
`timescale 1ns/1ps
interface timing_if;
  logic start;
  logic tick;
  logic [3:0] sampling_time_field;
  logic [3:0] settling_time_field;
  logic [1:0] input_mode_select;
  logic sample_active;
  logic settle_active;
  logic done;
  modport ctrl (output start, tick, sampling_time_field, settling_time_field,
    input_mode_select, input sample_active, settle_active, done);
  modport timer (input start, tick, sampling_time_field, settling_time_field,
    input_mode_select, output sample_active, settle_active, done);
endinterface : timing_if
